// [common/gpift_defines.svh]
`ifndef GPIFT_DEFINES_SVH
`define GPIFT_DEFINES_SVH

// register byte offsets
`define GPIFT_ADDR_CONFIG 8'h00
`define GPIFT_ADDR_STATUS 8'h04
`define GPIFT_ADDR_CONTROL 8'h08
`define GPIFT_ADDR_PULLDOWN 8'h0c

// config register field positions
`define GPIFT_CFG_INEN 0
`define GPIFT_CFG_OUTEN 1
`define GPIFT_CFG_OUTLVL 2
`define GPIFT_CFG_CODE_LSB 4
`define GPIFT_CFG_CHSEL_LSB 8
`define GPIFT_CFG_SYNC_LSB 12
`define GPIFT_CFG_RESET 16'h0000
`define GPIFT_PULL_RESET 8'h00

// request bit positions, shared by pin and control register
`define GPIFT_REQ_SLEEP 0
`define GPIFT_REQ_WAKE 1
`define GPIFT_REQ_FAULT 2
`define GPIFT_REQ_IDN 3
`define GPIFT_REQ_IUP 4
`define GPIFT_REQ_VDN 5
`define GPIFT_REQ_VUP 6
`define GPIFT_REQ_PROT 7
`define GPIFT_REQ_CLR 8
`define GPIFT_REQ_LOAD 9
`define GPIFT_REQ_STOP 10
`define GPIFT_REQ_RST 11
`define GPIFT_REQ_W 12
`define GPIFT_CTRL_SAVE 12
`define GPIFT_CTRL_CHAN_LSB 16

// input function codes
`define GPIFT_FN_SLEEP 4'h0
`define GPIFT_FN_FAULT 4'h2
`define GPIFT_FN_CURRENT_OUTPUT 4'h3
`define GPIFT_FN_VOLTAGE_OUTPUT 4'h4
`define GPIFT_FN_PROT 4'h5
`define GPIFT_FN_CLR 4'h7
`define GPIFT_FN_LOAD 4'h8
`define GPIFT_FN_STOP 4'h9
`define GPIFT_FN_RST 4'hb

// boot settle cycles before the power-on sample
`define GPIFT_BOOT_CYCLES 2'h3

// axi responses
`define GPIFT_RESP_OKAY 2'h0
`define GPIFT_RESP_SLVERR 2'h2

`endif

// [common/gpift_pkg.sv]
`include "gpift_defines.svh"

package gpift_pkg;

    // pin input function codes
    typedef enum logic [3:0] {
        FN_SLEEP = `GPIFT_FN_SLEEP,
        FN_FAULT = `GPIFT_FN_FAULT,
        FN_CURRENT_OUTPUT = `GPIFT_FN_CURRENT_OUTPUT,
        FN_VOLTAGE_OUTPUT = `GPIFT_FN_VOLTAGE_OUTPUT,
        FN_PROT = `GPIFT_FN_PROT,
        FN_CLR = `GPIFT_FN_CLR,
        FN_LOAD = `GPIFT_FN_LOAD,
        FN_STOP = `GPIFT_FN_STOP,
        FN_RST = `GPIFT_FN_RST
    } gpift_fn_t;

    // pin configuration, bit 0 last
    typedef struct packed {
        logic [3:0] syncSel;
        logic [3:0] chSel;
        logic [3:0] code;
        logic pad;
        logic outLevel;
        logic outEn;
        logic inEn;
    } gpift_cfg_t;

    // actions handed to the converter core
    typedef struct packed {
        logic deepSleep;
        logic [3:0] ioutDown;
        logic [3:0] voutDown;
        logic [7:0] voutPull;
        logic faultDump;
        logic protect;
        logic clear;
        logic [3:0] load;
        logic [3:0] stopWave;
        logic devReset;
    } gpift_act_t;

endpackage

// [rtl/gpift_top.sv]
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "gpift_defines.svh"

module gpift_top (
    // clock and power-up reset
    input wire logic mclk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // multifunction pin
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    // actions toward the converter core
    output gpift_pkg::gpift_act_t act
);
    import gpift_pkg::*;

    // request vector for a function code and edge pair
    function automatic logic [`GPIFT_REQ_W-1:0] reqForCode(
        input logic [3:0] code, input logic fall, input logic rise);
        logic [`GPIFT_REQ_W-1:0] r;
        r = '0;
        case (code)
            FN_SLEEP: begin
                r[`GPIFT_REQ_SLEEP] = fall;
                r[`GPIFT_REQ_WAKE] = rise;
            end
            FN_FAULT: r[`GPIFT_REQ_FAULT] = fall;
            FN_CURRENT_OUTPUT: begin
                r[`GPIFT_REQ_IDN] = fall;
                r[`GPIFT_REQ_IUP] = rise;
            end
            FN_VOLTAGE_OUTPUT: begin
                r[`GPIFT_REQ_VDN] = fall;
                r[`GPIFT_REQ_VUP] = rise;
            end
            FN_PROT: r[`GPIFT_REQ_PROT] = fall;
            FN_CLR: r[`GPIFT_REQ_CLR] = fall;
            FN_LOAD: r[`GPIFT_REQ_LOAD] = fall;
            FN_STOP: r[`GPIFT_REQ_STOP] = fall;
            FN_RST: r[`GPIFT_REQ_RST] = fall;
            // unlisted codes do nothing
            default: r = '0;
        endcase
        return r;
    endfunction

    // live and nonvolatile configuration
    gpift_cfg_t cfg_q;
    gpift_cfg_t nv_q;
    logic [7:0] pull_q; // per-channel pulldown setting
    // pin synchroniser and previous sample
    logic pinS1_q;
    logic pinS2_q;
    logic pinPrev_q;
    // boot sequencing
    logic [1:0] bootCnt_q;
    logic booted_q;
    // output state
    logic deepSleep_q;
    logic [3:0] ioutDown_q;
    logic [3:0] voutDown_q;
    logic faultDump_q;
    logic protect_q;
    logic clear_q;
    logic [3:0] load_q;
    logic [3:0] stopWave_q;
    logic devReset_q;
    // axi holding registers
    logic awHeld_q;
    logic [7:0] awAddr_q;
    logic wHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // byte-lane write mask from strobes
    wire [31:0] byteMask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign byteMask[gi*8 +: 8] = {8{wStrb_q[gi]}};
        end
    endgenerate

    // write decode
    wire doWrite = awHeld_q & wHeld_q & ~bvalid_q;
    wire [31:0] wMasked = wData_q & byteMask;
    wire wrCfg = doWrite & (awAddr_q == `GPIFT_ADDR_CONFIG);
    wire wrStat = doWrite & (awAddr_q == `GPIFT_ADDR_STATUS);
    wire wrCtrl = doWrite & (awAddr_q == `GPIFT_ADDR_CONTROL);
    wire wrPull = doWrite & (awAddr_q == `GPIFT_ADDR_PULLDOWN);
    wire wrHit = wrCfg | wrStat | wrCtrl | wrPull;
    wire [15:0] cfgNext = (cfg_q & ~byteMask[15:0])
        | wMasked[15:0];

    // read decode
    wire arHit = (araddr == `GPIFT_ADDR_CONFIG)
        | (araddr == `GPIFT_ADDR_STATUS)
        | (araddr == `GPIFT_ADDR_CONTROL)
        | (araddr == `GPIFT_ADDR_PULLDOWN);
    wire [31:0] statusWord = {21'h0, booted_q, deepSleep_q,
        voutDown_q, ioutDown_q, pinS2_q};
    wire [31:0] readMux =
        (araddr == `GPIFT_ADDR_CONFIG) ? {16'h0, cfg_q} :
        (araddr == `GPIFT_ADDR_STATUS) ? statusWord :
        (araddr == `GPIFT_ADDR_PULLDOWN) ? {24'h0, pull_q} :
        32'h0;

    // axi handshakes
    assign awready = ~awHeld_q & ~bvalid_q;
    assign wready = ~wHeld_q & ~bvalid_q;
    assign arready = ~rvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // direction from the enable bits, input wins
    assign pinOe = cfg_q.outEn & ~cfg_q.inEn;
    assign pinOut = cfg_q.outLevel;

    wire pinFall = pinPrev_q & ~pinS2_q;
    wire pinRise = ~pinPrev_q & pinS2_q;
    // one-shot boot sample of the settled level
    wire bootFire = ~booted_q & (bootCnt_q == `GPIFT_BOOT_CYCLES);
    // the pin does nothing unless the input is enabled
    wire pinMapped = cfg_q.inEn;
    wire [`GPIFT_REQ_W-1:0] pinEdgeReq =
        reqForCode(cfg_q.code, pinFall, pinRise);
    wire [`GPIFT_REQ_W-1:0] pinBootReq =
        reqForCode(cfg_q.code, ~pinS2_q, pinS2_q);
    wire [`GPIFT_REQ_W-1:0] pinRaw = !pinMapped ? '0 :
        booted_q ? pinEdgeReq : (bootFire ? pinBootReq : '0);
    // pin reset only when the mapping is saved
    wire nvReset = nv_q.inEn & (nv_q.code == FN_RST);
    wire [`GPIFT_REQ_W-1:0] nvMask =
        {nvReset, {(`GPIFT_REQ_W-1){1'b1}}};
    wire [`GPIFT_REQ_W-1:0] pinReq = pinRaw & nvMask;

    // software bits of the mapped function are blocked
    wire [`GPIFT_REQ_W-1:0] swBlock = pinMapped ?
        reqForCode(cfg_q.code, 1'b1, 1'b1) : '0;
    wire [`GPIFT_REQ_W-1:0] swReq = wrCtrl ?
        (wMasked[`GPIFT_REQ_W-1:0] & ~swBlock) : '0;
    wire swSave = wrCtrl & wMasked[`GPIFT_CTRL_SAVE];
    wire [3:0] swChan = wMasked[`GPIFT_CTRL_CHAN_LSB +: 4];

    // sleep blocks everything but wake and reset
    wire [`GPIFT_REQ_W-1:0] awakeMask = deepSleep_q ?
        ((`GPIFT_REQ_W'(1) << `GPIFT_REQ_WAKE)
        | (`GPIFT_REQ_W'(1) << `GPIFT_REQ_RST)) : '1;
    wire [`GPIFT_REQ_W-1:0] pinGo = pinReq & awakeMask;
    wire [`GPIFT_REQ_W-1:0] swGo = swReq & awakeMask;
    wire [`GPIFT_REQ_W-1:0] anyGo = pinGo | swGo;

    // per-channel masks, pin uses the select field
    wire [3:0] chOf [`GPIFT_REQ_W]; // channels hit by each request
    generate
        for (gi = 0; gi < `GPIFT_REQ_W; gi++) begin : g_chan
            assign chOf[gi] = ({4{pinGo[gi]}} & cfg_q.chSel)
                | ({4{swGo[gi]}} & swChan);
        end
    endgenerate
    wire [3:0] iDnCh = chOf[`GPIFT_REQ_IDN];
    wire [3:0] iUpCh = chOf[`GPIFT_REQ_IUP];
    wire [3:0] vDnCh = chOf[`GPIFT_REQ_VDN];
    wire [3:0] vUpCh = chOf[`GPIFT_REQ_VUP];
    wire [3:0] stopCh = chOf[`GPIFT_REQ_STOP];
    // load needs both sync selection and select
    wire [3:0] loadCh = chOf[`GPIFT_REQ_LOAD] & cfg_q.syncSel;
    wire devRst = anyGo[`GPIFT_REQ_RST];

    // action outputs, all from flip-flops
    assign act.deepSleep = deepSleep_q;
    assign act.ioutDown = ioutDown_q;
    assign act.voutDown = voutDown_q;
    assign act.voutPull = pull_q;
    assign act.faultDump = faultDump_q;
    assign act.protect = protect_q;
    assign act.clear = clear_q;
    assign act.load = load_q;
    assign act.stopWave = stopWave_q;
    assign act.devReset = devReset_q;

    // axi write channel capture and response
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wHeld_q <= 1'b0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `GPIFT_RESP_OKAY;
        end else begin
            // address taken alone or with data
            if (awvalid & awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            // data taken alone or with address
            if (wvalid & wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            // both present: commit and answer
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wrHit ? `GPIFT_RESP_OKAY : `GPIFT_RESP_SLVERR;
            end else if (bvalid_q & bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `GPIFT_RESP_OKAY;
        end else if (arvalid & arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= readMux;
            rresp_q <= arHit ? `GPIFT_RESP_OKAY : `GPIFT_RESP_SLVERR;
        end else if (rvalid_q & rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // two-stage pin synchroniser and edge history
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinS1_q <= 1'b0;
            pinS2_q <= 1'b0;
            pinPrev_q <= 1'b0;
        end else begin
            pinS1_q <= pinIn;
            pinS2_q <= pinS1_q;
            pinPrev_q <= pinS2_q;
        end
    end

    // settle count, then one boot action
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bootCnt_q <= 2'h0;
            booted_q <= 1'b0;
        end else if (devRst) begin
            // device reset repeats the boot sample
            bootCnt_q <= 2'h0;
            booted_q <= 1'b0;
        end else if (bootFire) begin
            booted_q <= 1'b1;
        end else if (!booted_q) begin
            bootCnt_q <= bootCnt_q + 2'h1;
        end
    end

    // configuration, nonvolatile copy and pulldowns
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_q <= gpift_cfg_t'(`GPIFT_CFG_RESET);
            nv_q <= gpift_cfg_t'(`GPIFT_CFG_RESET);
            pull_q <= `GPIFT_PULL_RESET;
        end else begin
            // device reset reloads only the saved copy
            if (devRst) begin
                cfg_q <= nv_q;
            end else if (wrCfg) begin
                cfg_q <= gpift_cfg_t'(cfgNext);
            end
            // save command stores the live setting
            if (swSave) begin
                nv_q <= cfg_q;
            end
            if (wrPull & wStrb_q[0]) begin
                pull_q <= wData_q[7:0];
            end
        end
    end

    // persistent output state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            deepSleep_q <= 1'b0;
            ioutDown_q <= 4'h0;
            voutDown_q <= 4'h0;
        end else if (devRst) begin
            deepSleep_q <= 1'b0;
            ioutDown_q <= 4'h0;
            voutDown_q <= 4'h0;
        end else begin
            if (anyGo[`GPIFT_REQ_SLEEP]) begin
                deepSleep_q <= 1'b1;
            end else if (anyGo[`GPIFT_REQ_WAKE]) begin
                deepSleep_q <= 1'b0;
            end
            ioutDown_q <= (ioutDown_q | iDnCh) & ~iUpCh;
            voutDown_q <= (voutDown_q | vDnCh) & ~vUpCh;
        end
    end

    // one-cycle action pulses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            faultDump_q <= 1'b0;
            protect_q <= 1'b0;
            clear_q <= 1'b0;
            load_q <= 4'h0;
            stopWave_q <= 4'h0;
            devReset_q <= 1'b0;
        end else begin
            faultDump_q <= anyGo[`GPIFT_REQ_FAULT];
            protect_q <= anyGo[`GPIFT_REQ_PROT];
            clear_q <= anyGo[`GPIFT_REQ_CLR];
            load_q <= loadCh;
            stopWave_q <= stopCh;
            devReset_q <= devRst;
        end
    end

endmodule

// [testbench/gpift_pin_drv.sv]
`timescale 1ns/1ps
module gpift_pin_drv (
    // clock
    input wire logic mclk,
    // wanted level and lag in cycles
    input wire logic want,
    input wire logic [1:0] lag,
    // level on the pin
    output logic pinIn
);
    logic [2:0] hist_q; // past wanted levels
    // strap or controller answering late
    always_ff @(posedge mclk) begin
        hist_q <= {hist_q[1:0], want};
    end
    assign pinIn = (lag == 2'h0) ? want : hist_q[lag - 2'h1];
endmodule

// [testbench/gpift_top_props.sv]
`timescale 1ns/1ps
module gpift_top_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // core actions
    input wire gpift_pkg::gpift_act_t act
);
    import gpift_pkg::*;
    logic wrSeen_q; // some write address taken
    logic [11:0] pulseVec; // every one-shot output
    assign pulseVec = {act.faultDump, act.protect, act.clear, act.load,
        act.stopWave, act.devReset};
    // note the first write, nothing may act before it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrSeen_q <= 1'h0;
        end else if (awvalid && awready) begin
            wrSeen_q <= 1'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_asleep;
        act.deepSleep [*3];
    endsequence
    sequence s_wjoint;
        awvalid && awready && wvalid && wready;
    endsequence
    property p_idle;
        !wrSeen_q |-> act == '0;
    endproperty
    property p_once;
        pulseVec != 12'h000 |=> pulseVec == 12'h000;
    endproperty
    property p_dev;
        act.devReset |-> ##[1:2] (!act.deepSleep && act.ioutDown == 4'h0);
    endproperty
    property p_sleep;
        s_asleep |-> pulseVec[11:1] == 11'h000;
    endproperty
    property p_wlat;
        s_wjoint |-> ##2 bvalid;
    endproperty
    property p_rlat;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    property p_busy;
        bvalid |-> !awready && !wready;
    endproperty
    property p_pull;
        $changed(act.voutPull) |-> $rose(bvalid);
    endproperty
    a_idle: assert property (p_idle)
        else $error("action before any configuration");
    a_once: assert property (p_once)
        else $error("pulse longer than one cycle");
    a_dev: assert property (p_dev)
        else $error("levels kept over device reset");
    a_sleep: assert property (p_sleep)
        else $error("action while asleep");
    a_wlat: assert property (p_wlat)
        else $error("write answer late");
    a_rlat: assert property (p_rlat)
        else $error("read answer late");
    a_busy: assert property (p_busy)
        else $error("write taken while answering");
    a_pull: assert property (p_pull)
        else $error("pulldown moved without a write");
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import gpift_pkg::*;
    // bus side
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, pinOut, pinOe;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    gpift_act_t act;
    // pin side
    logic want = 1'h1;
    logic [1:0] lag = 2'h0;
    logic drvLvl;
    logic pinWire;
    // scoring
    int miscompares = 0;
    int checked = 0;
    int seed = 14;
    int cnt = 0;
    logic [11:0] acc = 12'h000;
    logic [11:0] pulses;
    logic [3:0] codes [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8,
        4'h9};
    assign pinWire = pinOe ? pinOut : drvLvl;
    assign pulses = {act.faultDump, act.protect, act.clear, act.load,
        act.stopWave, act.devReset};
    always #10 mclk = ~mclk;
    gpift_top dut (.mclk(mclk), .rst(rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .pinIn(pinWire),
        .pinOut(pinOut), .pinOe(pinOe), .act(act));
    gpift_pin_drv drv (.mclk(mclk), .want(want), .lag(lag),
        .pinIn(drvLvl));
    // gather pulses away from the driving edge
    always @(negedge mclk) begin
        if (|pulses) begin
            acc = acc | pulses;
            cnt++;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string nm);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        tmo(n);
        chk(bresp, er, "bresp");
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        tmo(n);
        chk(rresp, er, "rresp");
        if (er == 2'h0) chk(rdata, ed, "rdata");
        rready <= 1'h0;
    endtask
    task automatic pin(input logic v);
        @(posedge mclk);
        want <= v;
    endtask
    // settle, then compare pulses and levels with the model
    task automatic look(input logic [11:0] ep, input logic [8:0] lv);
        repeat (14) @(posedge mclk);
        chk(acc, ep, "pulses");
        chk(cnt, ep != 12'h000, "pulse count");
        chk({act.deepSleep, act.ioutDown, act.voutDown}, lv, "lv");
        acc = 12'h000;
        cnt = 0;
    endtask
    initial begin
        logic [3:0] ch;
        logic [3:0] sy;
        logic [7:0] pd;
        logic [11:0] ef;
        logic [8:0] lvl;
        lvl = 9'h000;
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        rd(8'h0c, 32'h0, 2'h0);
        rd(8'h04, 32'h401, 2'h0);
        rd(8'h10, 32'h0, 2'h2);
        wr(8'h10, 32'h1, 2'h2);
        pin(1'h0);
        look(12'h000, lvl);
        pin(1'h1);
        pd = 8'($random(seed));
        wr(8'h0c, {24'h0, pd}, 2'h0);
        rd(8'h0c, {24'h0, pd}, 2'h0);
        chk(act.voutPull, pd, "pulldown");
        wr(8'h00, 32'h6, 2'h0);
        chk({pinOe, pinOut}, 2'h3, "drive");
        wr(8'h00, 32'h3, 2'h0);
        chk(pinOe, 1'h0, "drive");
        rd(8'h00, 32'h3, 2'h0);
        foreach (codes[i]) begin
            ch = 4'($random(seed)) | 4'h1;
            sy = 4'($random(seed));
            lag <= 2'($random(seed));
            wr(8'h00, {16'h0, sy, ch, codes[i], 4'h1}, 2'h0);
            for (int e = 0; e < 2; e++) begin
                ef = 12'h000;
                case (codes[i])
                    4'h0: lvl[8] = (e == 0);
                    4'h2: ef[11] = (e == 0);
                    4'h3: lvl[7:4] = e ? lvl[7:4] & ~ch : lvl[7:4] | ch;
                    4'h4: lvl[3:0] = e ? lvl[3:0] & ~ch : lvl[3:0] | ch;
                    4'h5: ef[10] = (e == 0);
                    4'h7: ef[9] = (e == 0);
                    4'h8: ef[8:5] = e ? 4'h0 : ch & sy;
                    default: ef[4:1] = e ? 4'h0 : ch;
                endcase
                pin(e[0]);
                look(ef, lvl);
                if (codes[i] == 4'h0 && e == 0) begin
                    wr(8'h08, 32'h4, 2'h0);
                    look(12'h000, lvl);
                end
            end
        end
        wr(8'h00, 32'h21, 2'h0);
        wr(8'h08, 32'h4, 2'h0);
        look(12'h000, lvl);
        wr(8'h00, 32'h20, 2'h0);
        pin(1'h0);
        look(12'h000, lvl);
        wr(8'h08, 32'h4, 2'h0);
        look(12'h800, lvl);
        wr(8'h08, 32'h50400, 2'h0);
        look(12'h00a, lvl);
        pin(1'h1);
        wr(8'h00, 32'hb1, 2'h0);
        pin(1'h0);
        pin(1'h1);
        look(12'h000, lvl);
        wr(8'h08, 32'h1000, 2'h0);
        pin(1'h0);
        pin(1'h1);
        look(12'h001, lvl);
        wr(8'h00, 32'h21, 2'h0);
        wr(8'h08, 32'h800, 2'h0);
        look(12'h001, lvl);
        rd(8'h00, 32'hb1, 2'h0);
        ch = 4'($random(seed)) | 4'h1;
        wr(8'h00, {20'h0, ch, 8'h41}, 2'h0);
        wr(8'h08, 32'h1000, 2'h0);
        pin(1'h0);
        lvl[3:0] = ch;
        look(12'h000, lvl);
        wr(8'h08, 32'h800, 2'h0);
        look(12'h001, lvl);
        pin(1'h1);
        lvl[3:0] = 4'h0;
        look(12'h000, lvl);
        conclude();
    end
endmodule
bind gpift_top gpift_top_props u_props (.mclk(mclk), .rst(rst),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .act(act));
